// >>> design/mac_ctrl_pkg.sv
// Package with register map, field positions, timing constants and carrier types of the MAC control block.
package mac_ctrl_pkg;

    localparam int unsigned CLOCK_PERIOD_NS = 4;

    // Register byte offsets on the 32-bit register bus.
    localparam logic [7:0] REG_COMMAND_CONFIG = 8'h00;
    localparam logic [7:0] REG_STATS_BASE     = 8'h40;
    localparam int unsigned STAT_COUNT        = 8;

    // Statistics counter indices; counter i sits at REG_STATS_BASE + 4*i.
    localparam int unsigned STAT_FRAMES_TX_OK = 0;
    localparam int unsigned STAT_FRAMES_RX_OK = 1;
    localparam int unsigned STAT_FCS_ERRORS   = 2;
    localparam int unsigned STAT_ALIGN_ERRORS = 3;
    localparam int unsigned STAT_OCTETS_TX_OK = 4;
    localparam int unsigned STAT_OCTETS_RX_OK = 5;
    localparam int unsigned STAT_PAUSE_TX     = 6;
    localparam int unsigned STAT_PAUSE_RX     = 7;

    // Command register field positions.
    localparam int unsigned BIT_TX_ENABLE      = 0;
    localparam int unsigned BIT_RX_ENABLE      = 1;
    localparam int unsigned BIT_SOFT_RESET     = 13;
    localparam int unsigned BIT_LINE_LOOPBACK  = 27;
    localparam int unsigned BIT_BCAST_DROP     = 28;
    localparam int unsigned BIT_CRC_INJECT     = 29;
    localparam int unsigned BIT_NO_FIFO_PAUSE  = 30;
    localparam int unsigned BIT_COUNTER_CLEAR  = 31;

    // Plainly stored bits: 0..9, 15, 22..24, 26..28, 30.
    localparam logic [31:0] CMD_STORE_MASK  = 32'h5dc0_83ff;
    localparam logic [31:0] CMD_RESET_VALUE = 32'h0000_0000;

    // Durations of the two self-clearing sequences.
    localparam int unsigned COUNTER_CLEAR_TIME_NS = 16;
    localparam int unsigned SOFT_RESET_TIME_NS    = 64;
    localparam int unsigned COUNTER_CLEAR_CYCLES  =
        (COUNTER_CLEAR_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned SOFT_RESET_CYCLES     =
        (SOFT_RESET_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    typedef struct packed {
        logic [63:0] data;
        logic [7:0]  ctrl;
    } xgmii_t;

    typedef struct packed {
        logic        valid;
        logic        ok;
        logic        pause;
        logic [15:0] octets;
    } tx_event_t;

    typedef struct packed {
        logic        valid;
        logic        ok;
        logic        fcs_err;
        logic        align_err;
        logic        pause;
        logic        broadcast;
        logic [15:0] octets;
    } rx_event_t;

endpackage : mac_ctrl_pkg

// >>> design/stat_counter.sv
// Statistics accumulator that adds a step per event and clears on command.
`timescale 1ns/1ns
module stat_counter
    import mac_ctrl_pkg::*;
#(
    parameter int unsigned WIDTH = 32
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             clear,
    input  wire logic             inc,
    input  wire logic [15:0]      step,
    output logic      [WIDTH-1:0] count
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    // A clear in progress takes precedence over counting so the zeroing is complete.
    assign count_d = clear ? '0 : (inc ? count_q + WIDTH'(step) : count_q);
    assign count   = count_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : stat_counter

// >>> design/timed_sequence.sv
// Timed busy sequence started by a pulse, used by the counter clear and soft reset command bits.
`timescale 1ns/1ns
module timed_sequence
    import mac_ctrl_pkg::*;
#(
    parameter int unsigned CYCLES = 4
) (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    logic [15:0] left_q;
    logic        busy_q;
    logic        last;

    assign last = busy_q && (left_q == 16'h0001);
    assign busy = busy_q;
    assign done = last;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            busy_q <= 1'b0;
            left_q <= 16'h0000;
        end else if (start && !busy_q) begin
            busy_q <= 1'b1;
            left_q <= 16'(CYCLES);
        end else if (busy_q) begin
            busy_q <= !last;
            left_q <= left_q - 16'h0001;
        end
    end

endmodule : timed_sequence

// >>> design/mac_ctrl_reset_statistics.sv
// Command register, loopback and filter controls, soft reset and statistics counters of the 10G MAC.
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns

// Functional notes
// - Line loopback sends receive traffic to transmit.
// - Broadcast drop bit discards received broadcasts.
// - CRC inject corrupts one frame, self clears.
// - No-FIFO-pause bit blocks FIFO pause generation.
// - Counter clear zeroes statistics, then self clears.
// - Soft reset zeroes statistics, flushes both FIFOs.
// - Soft reset forces transmit, receive enables low.
// - Soft reset keeps other configuration unchanged.
// - Soft reset bit self clears when done.
// - Count good transmitted frames, pause included.
// - Count good received frames, pause included.
// - Count received frames with FCS mismatch.
// - Count received frames with alignment error.
// - Sum payload octets of good transmitted frames.
// - Sum payload octets of good received frames.
// - Count good transmitted pause frames.
// - Count good received pause frames.
// - Bit 13 write starts soft reset sequence.
module mac_ctrl_reset_statistics
    import mac_ctrl_pkg::*;
#(
    parameter int unsigned STAT_WIDTH   = 32,
    parameter int unsigned CLEAR_CYCLES = COUNTER_CLEAR_CYCLES,
    parameter int unsigned SRST_CYCLES  = SOFT_RESET_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire xgmii_t      rx_xgmii,
    input  wire xgmii_t      tx_mac_xgmii,
    output xgmii_t           tx_xgmii,
    input  wire logic        tx_sof,
    input  wire tx_event_t   tx_event,
    input  wire rx_event_t   rx_event,
    input  wire logic        fifo_pause_req,
    output logic             pause_gen_req,
    output logic             rx_drop_frame,
    output logic             tx_crc_corrupt,
    output logic             fifo_flush,
    output logic             transmit_enable,
    output logic             receive_enable
);

    logic [31:0] cmd_q;
    logic [31:0] cmd_d;
    logic        ack_q;
    logic [31:0] readdata_q;
    logic        arm_q;
    logic        corrupt_q;
    xgmii_t      tx_xgmii_q;
    logic        drop_q;

    logic        req;
    logic        take;
    logic        wr_cmd;
    logic [31:0] be_mask;
    logic [31:0] wr_mask;
    logic        srst_start;
    logic        srst_busy;
    logic        srst_done;
    logic        cnt_start;
    logic        cnt_busy;
    logic        cnt_done;
    logic        stat_clear;
    logic        arm_d;
    logic        arm_set;
    logic        corrupt_d;
    logic        stat_hit;
    logic [2:0]  stat_idx;
    logic [31:0] cmd_view;
    logic [31:0] read_value;

    logic                  line_loopback_enable;
    logic                  broadcast_drop_enable;
    logic                  no_fifo_pause;

    logic                  stat_inc  [STAT_COUNT];
    logic [15:0]           stat_step [STAT_COUNT];
    logic [STAT_WIDTH-1:0] stat_val  [STAT_COUNT];

    // ------------------------------------------------------------------
    // Register bus slave: every access is answered one cycle after it
    // arrives, so waitrequest is high in the first cycle and low in the
    // second, at whose closing edge the access takes effect.
    // ------------------------------------------------------------------
    assign req             = avs_read || avs_write;
    assign take            = req && ack_q;
    assign avs_waitrequest = req && !ack_q;
    assign avs_readdata    = readdata_q;

    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_mask = be_mask & CMD_STORE_MASK;
    assign wr_cmd  = take && avs_write && (avs_address == REG_COMMAND_CONFIG);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ack_q      <= 1'b0;
            readdata_q <= 32'h0000_0000;
        end else begin
            ack_q      <= req && !ack_q;
            readdata_q <= (req && !ack_q && avs_read) ? read_value : readdata_q;
        end
    end

    // ------------------------------------------------------------------
    // Self-clearing commands.
    // ------------------------------------------------------------------
    assign srst_start = wr_cmd && avs_byteenable[1] && avs_writedata[BIT_SOFT_RESET];
    assign cnt_start  = wr_cmd && avs_byteenable[3] && avs_writedata[BIT_COUNTER_CLEAR];

    timed_sequence #(
        .CYCLES (SRST_CYCLES)
    ) u_soft_reset (
        .clock (clock),
        .nrst  (nrst),
        .start (srst_start),
        .busy  (srst_busy),
        .done  (srst_done)
    );

    timed_sequence #(
        .CYCLES (CLEAR_CYCLES)
    ) u_counter_clear (
        .clock (clock),
        .nrst  (nrst),
        .start (cnt_start),
        .busy  (cnt_busy),
        .done  (cnt_done)
    );

    assign stat_clear = cnt_busy || srst_busy;
    assign fifo_flush = srst_busy;

    // ------------------------------------------------------------------
    // Command register. Only the stored bits take writes; the enables are
    // held low from the start of a soft reset until it ends, while every
    // other stored bit keeps its written value.
    // ------------------------------------------------------------------
    always_comb begin
        cmd_d = cmd_q;
        if (wr_cmd) begin
            cmd_d = (cmd_q & ~wr_mask) | (avs_writedata & wr_mask);
        end
        if (srst_start || srst_busy) begin
            cmd_d[BIT_TX_ENABLE] = 1'b0;
            cmd_d[BIT_RX_ENABLE] = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cmd_q <= CMD_RESET_VALUE;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    assign transmit_enable       = cmd_q[BIT_TX_ENABLE];
    assign receive_enable        = cmd_q[BIT_RX_ENABLE];
    assign line_loopback_enable  = cmd_q[BIT_LINE_LOOPBACK];
    assign broadcast_drop_enable = cmd_q[BIT_BCAST_DROP];
    assign no_fifo_pause         = cmd_q[BIT_NO_FIFO_PAUSE];

    // Readback shows the live state of the self-clearing bits.
    always_comb begin
        cmd_view                    = cmd_q;
        cmd_view[BIT_SOFT_RESET]    = srst_busy;
        cmd_view[BIT_CRC_INJECT]    = arm_q;
        cmd_view[BIT_COUNTER_CLEAR] = cnt_busy;
    end

    // ------------------------------------------------------------------
    // Read decode. Counters are sampled into the read register only, so a
    // read leaves them counting.
    // ------------------------------------------------------------------
    assign stat_hit = (avs_address[7:5] == REG_STATS_BASE[7:5]) && (avs_address[1:0] == 2'b00);
    assign stat_idx = avs_address[4:2];

    always_comb begin
        read_value = 32'h0000_0000;
        if (avs_address == REG_COMMAND_CONFIG) begin
            read_value = cmd_view;
        end else if (stat_hit) begin
            read_value = 32'(stat_val[stat_idx]);
        end
    end

    // ------------------------------------------------------------------
    // CRC error injection. A write arms the request; the next frame start
    // consumes it and the whole of that frame is marked for a bad CRC. A
    // fresh write in the consuming cycle re-arms, so it is not lost.
    // ------------------------------------------------------------------
    assign arm_set   = wr_cmd && avs_byteenable[3] && avs_writedata[BIT_CRC_INJECT];
    assign arm_d     = arm_set || (arm_q && !tx_sof);
    assign corrupt_d = (tx_sof && arm_q) || (corrupt_q && !tx_event.valid);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            arm_q     <= 1'b0;
            corrupt_q <= 1'b0;
        end else begin
            arm_q     <= arm_d;
            corrupt_q <= corrupt_d;
        end
    end

    assign tx_crc_corrupt = corrupt_q;

    // ------------------------------------------------------------------
    // Data path controls.
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            tx_xgmii_q <= '0;
            drop_q     <= 1'b0;
        end else begin
            tx_xgmii_q <= line_loopback_enable ? rx_xgmii : tx_mac_xgmii;
            drop_q     <= rx_event.valid && rx_event.broadcast && broadcast_drop_enable;
        end
    end

    assign tx_xgmii      = tx_xgmii_q;
    assign rx_drop_frame = drop_q;
    assign pause_gen_req = fifo_pause_req && !no_fifo_pause;

    // ------------------------------------------------------------------
    // Statistics events.
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < STAT_COUNT; i++) begin
            stat_step[i] = 16'h0001;
        end
        stat_inc[STAT_FRAMES_TX_OK] = tx_event.valid && tx_event.ok;
        stat_inc[STAT_FRAMES_RX_OK] = rx_event.valid && rx_event.ok;
        stat_inc[STAT_FCS_ERRORS]   = rx_event.valid && rx_event.fcs_err;
        stat_inc[STAT_ALIGN_ERRORS] = rx_event.valid && rx_event.align_err;
        stat_inc[STAT_OCTETS_TX_OK] = tx_event.valid && tx_event.ok;
        stat_inc[STAT_OCTETS_RX_OK] = rx_event.valid && rx_event.ok;
        stat_inc[STAT_PAUSE_TX]     = tx_event.valid && tx_event.ok && tx_event.pause;
        stat_inc[STAT_PAUSE_RX]     = rx_event.valid && rx_event.ok && rx_event.pause;
        stat_step[STAT_OCTETS_TX_OK] = tx_event.octets;
        stat_step[STAT_OCTETS_RX_OK] = rx_event.octets;
    end

    for (genvar g = 0; g < STAT_COUNT; g++) begin : g_stat
        stat_counter #(
            .WIDTH (STAT_WIDTH)
        ) u_counter (
            .clock (clock),
            .nrst  (nrst),
            .clear (stat_clear),
            .inc   (stat_inc[g]),
            .step  (stat_step[g]),
            .count (stat_val[g])
        );
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    chk_loopback_path: assert property (
        line_loopback_enable |=> (tx_xgmii == $past(rx_xgmii)))
        else $error("Loopback did not forward receive traffic.");

    chk_broadcast_drop: assert property (
        (rx_event.valid && rx_event.broadcast) |=> (rx_drop_frame == $past(broadcast_drop_enable)))
        else $error("Broadcast drop decision wrong.");

    chk_crc_one_frame: assert property (
        (arm_q && tx_sof) |=> (tx_crc_corrupt && (arm_q == $past(arm_set))))
        else $error("Armed CRC error not applied to frame.");

    chk_fifo_pause_gate: assert property (
        no_fifo_pause |-> !pause_gen_req)
        else $error("FIFO pause escaped while disabled.");

    chk_counter_clear: assert property (
        cnt_start |=> cnt_busy [*2] ##0 (stat_val[STAT_FRAMES_TX_OK] == '0))
        else $error("Counter clear did not zero counters.");

    chk_clear_ends: assert property (
        cnt_start |-> ##[1:64] !cnt_busy)
        else $error("Counter clear bit never cleared.");

    chk_soft_flush: assert property (
        srst_start |=> (fifo_flush && stat_clear) ##1 (stat_val[STAT_FRAMES_RX_OK] == '0))
        else $error("Soft reset did not flush and clear.");

    chk_soft_enables: assert property (
        srst_start |=> (!transmit_enable && !receive_enable) throughout srst_busy [*2])
        else $error("Enables not forced low in soft reset.");

    chk_soft_keeps_cfg: assert property (
        (srst_busy && !wr_cmd) |=> (cmd_q[31:2] == $past(cmd_q[31:2])))
        else $error("Soft reset disturbed configuration.");

    chk_soft_self_clear: assert property (
        srst_start |-> ##[1:300] !srst_busy)
        else $error("Soft reset bit did not self clear.");

    chk_good_tx_count: assert property (
        (tx_event.valid && tx_event.ok && !stat_clear) |=>
            (stat_val[STAT_FRAMES_TX_OK] == $past(stat_val[STAT_FRAMES_TX_OK]) + 1'b1))
        else $error("Good transmit frame not counted.");

    chk_fcs_count: assert property (
        (rx_event.valid && rx_event.fcs_err && !stat_clear) |=>
            (stat_val[STAT_FCS_ERRORS] == $past(stat_val[STAT_FCS_ERRORS]) + 1'b1))
        else $error("FCS error not counted.");

    chk_rx_octets: assert property (
        (rx_event.valid && rx_event.ok && !stat_clear) |=>
            (stat_val[STAT_OCTETS_RX_OK] ==
             $past(stat_val[STAT_OCTETS_RX_OK]) + STAT_WIDTH'($past(rx_event.octets))))
        else $error("Receive octets not accumulated.");

    chk_read_answer: assert property (
        (avs_read && avs_waitrequest) |=> !avs_waitrequest)
        else $error("Read not answered in one cycle.");

endmodule : mac_ctrl_reset_statistics

// >>> tb/mac_far_side_model.sv
// Behavioural model of the PHY receive lane and the client transmit engine facing the MAC control block.
`timescale 1ns/1ns
module mac_far_side_model
    import mac_ctrl_pkg::*;
(
    input  wire logic clock,
    output xgmii_t    rx_xgmii,
    output xgmii_t    tx_mac_xgmii,
    output logic      tx_sof,
    output tx_event_t tx_event,
    output rx_event_t rx_event,
    output logic      fifo_pause_req
);
    logic [31:0] beat_q = 32'h0;

    // Both lanes change every cycle so a stale or swapped path shows at once.
    assign rx_xgmii     = {32'h0, beat_q, 8'h07};
    assign tx_mac_xgmii = {beat_q, 32'hffff_ffff, 8'hff};

    initial begin
        tx_sof = 1'b0;
        tx_event = '0;
        rx_event = '0;
        fifo_pause_req = 1'b0;
    end

    always @(posedge clock) begin
        beat_q <= beat_q + 32'h1;
    end

    // Idle report fields carry the inverse of the last report, never a copy of it.
    task automatic send_tx(input logic [1:0] flags, input logic [15:0] octets, input int gap);
        @(posedge clock);
        tx_sof <= 1'b1;
        @(posedge clock);
        tx_sof <= 1'b0;
        repeat (gap) @(posedge clock);
        tx_event <= {1'b1, flags, octets};
        @(posedge clock);
        tx_event <= {1'b0, ~flags, ~octets};
    endtask : send_tx

    task automatic send_rx(input logic [4:0] flags, input logic [15:0] octets);
        @(posedge clock);
        rx_event <= {1'b1, flags, octets};
        @(posedge clock);
        rx_event <= {1'b0, ~flags, ~octets};
    endtask : send_rx

    task automatic set_pause(input logic level);
        @(posedge clock);
        fifo_pause_req <= level;
    endtask : set_pause
endmodule : mac_far_side_model

// >>> tb/mac_ctrl_reset_statistics_tb_top.sv
// Self-checking testbench of the MAC control block: registers, loopback, filters, resets and statistics.
`timescale 1ns/1ns
module mac_ctrl_reset_statistics_tb_top
    import mac_ctrl_pkg::*;
;
    logic        clock;
    logic        nrst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    xgmii_t      rx_xgmii;
    xgmii_t      tx_mac_xgmii;
    xgmii_t      tx_xgmii;
    logic        tx_sof;
    tx_event_t   tx_event;
    rx_event_t   rx_event;
    logic        fifo_pause_req;
    logic        pause_gen_req, rx_drop_frame, tx_crc_corrupt, fifo_flush, transmit_enable, receive_enable;
    int          miscompares = 0;
    int          tests_run = 0;
    xgmii_t      seen;
    int          exp_cnt[8] = '{2, 3, 1, 1, 146, 206, 1, 1};

    mac_ctrl_reset_statistics dut (.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_xgmii(rx_xgmii), .tx_mac_xgmii(tx_mac_xgmii), .tx_xgmii(tx_xgmii),
        .tx_sof(tx_sof), .tx_event(tx_event), .rx_event(rx_event), .fifo_pause_req(fifo_pause_req),
        .pause_gen_req(pause_gen_req), .rx_drop_frame(rx_drop_frame), .tx_crc_corrupt(tx_crc_corrupt),
        .fifo_flush(fifo_flush), .transmit_enable(transmit_enable), .receive_enable(receive_enable));

    mac_far_side_model pm (.clock(clock), .rx_xgmii(rx_xgmii), .tx_mac_xgmii(tx_mac_xgmii), .tx_sof(tx_sof),
        .tx_event(tx_event), .rx_event(rx_event), .fifo_pause_req(fifo_pause_req));

    task automatic check(input logic [71:0] got, input logic [71:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) miscompares++;
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] d;
        bus(1'b1, addr, data, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, addr, 32'h0, d);
        check(72'(d), 72'(exp));
    endtask : rd_chk

    task automatic poll_clear(input int bitpos);
        logic [31:0] d;
        bus(1'b0, REG_COMMAND_CONFIG, 32'h0, d);
        check(72'(d[bitpos]), 72'h1);
        for (int i = 0; i < 40 && d[bitpos] !== 1'b0; i++) bus(1'b0, REG_COMMAND_CONFIG, 32'h0, d);
        check(72'(d[bitpos]), 72'h0);
    endtask : poll_clear

    task automatic stats_chk(input logic zero);
        for (int i = 0; i < STAT_COUNT; i++) rd_chk(REG_STATS_BASE + 8'(4 * i), zero ? 32'h0 : 32'(exp_cnt[i]));
    endtask : stats_chk

    task automatic t_reset();
        rd_chk(REG_COMMAND_CONFIG, CMD_RESET_VALUE);
        wr(8'h80, 32'hffff_ffff);
        rd_chk(8'h80, 32'h0);
        stats_chk(1'b1);
        wr(REG_COMMAND_CONFIG, CMD_STORE_MASK);
        rd_chk(REG_COMMAND_CONFIG, CMD_STORE_MASK);
    endtask : t_reset

    task automatic t_loopback();
        wr(REG_COMMAND_CONFIG, 32'h0);
        wr(REG_COMMAND_CONFIG, 32'h0800_0000);
        @(negedge clock);
        @(negedge clock);
        seen = rx_xgmii;
        @(negedge clock);
        check(tx_xgmii, seen);
        wr(REG_COMMAND_CONFIG, 32'h0);
        @(negedge clock);
        seen = tx_mac_xgmii;
        @(negedge clock);
        check(tx_xgmii, seen);
    endtask : t_loopback

    task automatic t_filters();
        wr(REG_COMMAND_CONFIG, 32'h5000_0000);
        pm.set_pause(1'b1);
        @(negedge clock);
        check(72'(pause_gen_req), 72'h0);
        pm.send_rx(5'b10001, 16'd80);
        @(negedge clock);
        check(72'(rx_drop_frame), 72'h1);
        wr(REG_COMMAND_CONFIG, 32'h0);
        @(negedge clock);
        check(72'(pause_gen_req), 72'h1);
        pm.send_rx(5'b10001, 16'd80);
        @(negedge clock);
        check(72'(rx_drop_frame), 72'h0);
        pm.set_pause(1'b0);
    endtask : t_filters

    task automatic t_stats();
        pm.send_tx(2'b10, 16'd100, 3);
        pm.send_tx(2'b11, 16'd46, 1);
        pm.send_tx(2'b01, 16'd200, 0);
        pm.send_rx(5'b10010, 16'd46);
        pm.send_rx(5'b01000, 16'd64);
        pm.send_rx(5'b00100, 16'd64);
        stats_chk(1'b0);
        wr(REG_COMMAND_CONFIG, 32'h8000_0000);
        poll_clear(BIT_COUNTER_CLEAR);
        stats_chk(1'b1);
    endtask : t_stats

    task automatic t_crc();
        wr(REG_COMMAND_CONFIG, 32'h2000_0000);
        for (int k = 1; k >= 0; k--) begin
            fork
                pm.send_tx(2'b10, 16'd64, 3);
                begin
                    repeat (4) @(negedge clock);
                    check(72'(tx_crc_corrupt), 72'(k));
                end
            join
        end
        rd_chk(REG_COMMAND_CONFIG, 32'h0);
    endtask : t_crc

    task automatic t_soft_reset();
        wr(REG_COMMAND_CONFIG, 32'h5000_0003);
        pm.send_rx(5'b10000, 16'd64);
        wr(REG_COMMAND_CONFIG, 32'h5000_2003);
        @(negedge clock);
        check(72'(fifo_flush), 72'h1);
        check(72'({transmit_enable, receive_enable}), 72'h0);
        poll_clear(BIT_SOFT_RESET);
        rd_chk(REG_COMMAND_CONFIG, 32'h5000_0000);
        stats_chk(1'b1);
    endtask : t_soft_reset

    task automatic summarize();
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        nrst = 1'b0;
        avs_address = 8'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_loopback();
        t_filters();
        t_stats();
        t_crc();
        t_soft_reset();
        summarize();
    end

    initial begin
        #40000;
        miscompares++;
        summarize();
    end
endmodule : mac_ctrl_reset_statistics_tb_top
